// file: include/icu_consts.svh
// Register offsets, field positions, reset values of the interrupt control unit
`ifndef ICU_CONSTS_SVH
`define ICU_CONSTS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ICU_OFF_NMI_STAT 8'h00
`define ICU_OFF_NMI_CTRL 8'h04
`define ICU_OFF_VECTOR 8'h08
`define ICU_OFF_MASK_LO 8'h0c
`define ICU_OFF_MASK_HI 8'h10
`define ICU_OFF_LEVEL_LO 8'h14
`define ICU_OFF_LEVEL_HI 8'h18
`define ICU_OFF_DEBUG 8'h1c
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ICU_BIT_EXT 0
`define ICU_BIT_EN 0
`define ICU_BIT_PIN 1
`define ICU_BIT_LOCK 2
`define ICU_BIT_TEST 3
// ----------------------------------------
// Reset values and encodings
// ----------------------------------------
`define ICU_MASK_RST 16'hffff
`define ICU_DBG_RST 6'h00
`define ICU_VEC_BASE 6'h10
`define ICU_VEC_NONE 6'h00
`endif

// file: include/icu_pkg.sv
// Types shared by the interrupt control unit
`default_nettype none
package icu_pkg;
  // All registered state of the top module
  typedef struct packed {
    logic pend;
    logic en;
    logic lock;
    logic test;
    logic prev;
    logic trap;
    logic irq;
    logic [31:0] mask;
    logic [5:0] vec;
    logic [5:0] dbg_rd;
    logic [5:0] dbg_req;
    logic [31:0] rdata;
    logic slverr;
  } icu_state_type;
endpackage
`default_nettype wire

// file: rtl/icu_prio.sv
// Priority encoder: highest-numbered active request wins
`timescale 1ns/1ns
`default_nettype none
module icu_prio (
  input wire logic [31:0] req_vec,
  output logic found,
  output logic [4:0] win
);
  // Ascending scan so the last hit is the highest number
  always_comb begin
    found = 1'b0;
    win = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (req_vec[i]) begin
        found = 1'b1;
        win = 5'(i);
      end
    end
  end
endmodule // icu_prio
`default_nettype wire

// file: rtl/icu_sync2.sv
// Two-flop synchroniser for an asynchronous pin
`timescale 1ns/1ns
`default_nettype none
module icu_sync2 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic din,
  output logic dout
);
  logic [1:0] sync_r;
  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_r <= 2'h3;
    end else begin
      sync_r <= {sync_r[0], din};
    end
  end
  assign dout = sync_r[1];
endmodule // icu_sync2
`default_nettype wire

// file: rtl/icu_top.sv
// Interrupt control unit: NMI pin handling and 32-source maskable encoder
//
// Behaviour
// [RULE_01] Pending status clears at reset and on every software read.
// [RULE_02] External flag bit 0 sets when a pin request occurs.
// [RULE_03] One-shot enable lets a falling edge trap; each trap clears it.
// [RULE_04] Lock enable traps on every falling edge, even during service.
// [RULE_05] Lock overrides one-shot enable; both clear means no traps.
// [RULE_06] Reset clears one-shot enable, lock enable and test bit.
// [RULE_07] Control bit 1 reads pin level uninverted; writes ignored.
// [RULE_08] Software writes zero into reserved control bits.
// [RULE_09] Vector register holds 6-bit winner code; bits 7 and 6 read zero.
// [RULE_10] Hardware updates the vector whenever the winner changes.
// [RULE_11] Vector is valid when the core reads it during acknowledge.
// [RULE_12] Higher request number has higher priority.
// [RULE_13] Low mask enables requests 0 to 15, resets to all ones.
// [RULE_14] High mask enables requests 16 to 31, resets to all ones.
// [RULE_15] Two read-only level registers show raw request inputs.
// [RULE_16] Debug keeps vector at last vector read and at request send.
// [RULE_17] Software changes request sources only with interrupts disabled.
// [RULE_18] Software waits one instruction after clearing before re-enabling.
// [RULE_19] Lock enable stays set until reset; writes cannot clear it.
// [RULE_20] Maskable requests are level sensitive.
// [RULE_21] Request 0 is reserved and not connected.
// [RULE_22] NMI pin is synchronised before edge detection.
// [RULE_23] Vector code is winning request number plus sixteen.
// [RULE_24] Request to core whenever an input is active and enabled.
// [RULE_25] Enabled falling edge raises trap and sets pending flag.
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "icu_consts.svh"
module icu_top
  import icu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic nmi_pin_n,
  input wire logic [31:0] irq_req,
  input wire logic ack_read,
  output logic nmi_trap,
  output logic irq_out,
  output logic [5:0] irq_vector
);

  // ----------------------------------------
  // State and nets
  // ----------------------------------------
  icu_state_type s_r;
  icu_state_type s_nxt;
  logic nmi_s;
  logic fall;
  logic trap_ok;
  logic setup;
  logic wr;
  logic rd;
  logic found;
  logic [4:0] win;
  logic [31:0] req_lvl;
  logic [31:0] req_eff;
  logic [31:0] rd_val;
  logic mapped;

  // ----------------------------------------
  // Pin synchroniser and priority encoder
  // ----------------------------------------
  // Pin is asynchronous; two flops before the edge detector
  icu_sync2 u_sync ( // RULE_22
    .pclk(pclk),
    .presetn(presetn),
    .din(nmi_pin_n),
    .dout(nmi_s)
  );

  // Request 0 tied off; levels pass straight, no latching
  assign req_lvl = {irq_req[31:1], 1'b0}; // RULE_21 RULE_20
  assign req_eff = req_lvl & s_r.mask; // RULE_13 RULE_14

  icu_prio u_prio ( // RULE_12
    .req_vec(req_eff),
    .found(found),
    .win(win)
  );

  // ----------------------------------------
  // Bus phase decode and edge detect
  // ----------------------------------------
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign fall = s_r.prev & ~nmi_s;
  // Lock makes the one-shot bit irrelevant
  assign trap_ok = s_r.lock | s_r.en; // RULE_05

  // ----------------------------------------
  // Read multiplexer
  // ----------------------------------------
  // Reserved bits read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    mapped = 1'b1;
    if (paddr == `ICU_OFF_NMI_STAT) begin
      rd_val[`ICU_BIT_EXT] = s_r.pend;
    end else if (paddr == `ICU_OFF_NMI_CTRL) begin
      rd_val[`ICU_BIT_EN] = s_r.en;
      rd_val[`ICU_BIT_PIN] = nmi_s; // RULE_07
      rd_val[`ICU_BIT_LOCK] = s_r.lock;
      rd_val[`ICU_BIT_TEST] = s_r.test;
    end else if (paddr == `ICU_OFF_VECTOR) begin
      rd_val[5:0] = s_r.vec; // RULE_09
    end else if (paddr == `ICU_OFF_MASK_LO) begin
      rd_val[15:0] = s_r.mask[15:0];
    end else if (paddr == `ICU_OFF_MASK_HI) begin
      rd_val[15:0] = s_r.mask[31:16];
    end else if (paddr == `ICU_OFF_LEVEL_LO) begin
      rd_val[15:0] = req_lvl[15:0]; // RULE_15
    end else if (paddr == `ICU_OFF_LEVEL_HI) begin
      rd_val[15:0] = req_lvl[31:16]; // RULE_15
    end else if (paddr == `ICU_OFF_DEBUG) begin
      rd_val[11:0] = {s_r.dbg_req, s_r.dbg_rd}; // RULE_16
    end else begin
      mapped = 1'b0;
    end
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.prev = nmi_s;
    // Trap pulse on an enabled falling edge
    s_nxt.trap = fall & trap_ok; // RULE_03 RULE_04 RULE_25
    if (s_nxt.trap) begin
      s_nxt.en = 1'b0; // RULE_03
    end
    // Read clears, but a same-cycle trap still sets the flag
    if (rd && paddr == `ICU_OFF_NMI_STAT) begin
      s_nxt.pend = 1'b0; // RULE_01
    end
    if (s_nxt.trap) begin
      s_nxt.pend = 1'b1; // RULE_02 RULE_25
    end
    // Software write lands after the trap clear, so a rearm is kept
    if (wr) begin
      if (paddr == `ICU_OFF_NMI_CTRL) begin
        s_nxt.en = pwdata[`ICU_BIT_EN];
        s_nxt.lock = s_r.lock | pwdata[`ICU_BIT_LOCK]; // RULE_19
        s_nxt.test = pwdata[`ICU_BIT_TEST];
      end else if (paddr == `ICU_OFF_MASK_LO) begin
        s_nxt.mask[15:0] = pwdata[15:0]; // RULE_13
      end else if (paddr == `ICU_OFF_MASK_HI) begin
        s_nxt.mask[31:16] = pwdata[15:0]; // RULE_14
      end
    end
    // Vector tracks the winner every cycle, one cycle behind
    s_nxt.irq = found; // RULE_24
    s_nxt.vec = found ? 6'(win) + `ICU_VEC_BASE : `ICU_VEC_NONE; // RULE_10 RULE_23
    // Debug captures: vector at its read, and at request send
    if (ack_read || (rd && paddr == `ICU_OFF_VECTOR)) begin
      s_nxt.dbg_rd = s_r.vec; // RULE_16 RULE_11
    end
    if (s_nxt.irq && !s_r.irq) begin
      s_nxt.dbg_req = s_nxt.vec; // RULE_16
    end
    // Read data registered in setup so the access edge sees a flop
    if (setup) begin
      s_nxt.rdata = rd_val;
      s_nxt.slverr = ~mapped;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r.pend <= 1'b0; // RULE_01
      s_r.en <= 1'b0; // RULE_06
      s_r.lock <= 1'b0; // RULE_06
      s_r.test <= 1'b0; // RULE_06
      s_r.prev <= 1'b1;
      s_r.trap <= 1'b0;
      s_r.irq <= 1'b0;
      s_r.mask <= {`ICU_MASK_RST, `ICU_MASK_RST}; // RULE_13 RULE_14
      s_r.vec <= `ICU_VEC_NONE;
      s_r.dbg_rd <= `ICU_DBG_RST; // RULE_16
      s_r.dbg_req <= `ICU_DBG_RST;
      s_r.rdata <= 32'h0000_0000;
      s_r.slverr <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Zero wait states; error only shown in the access phase
  assign pready = 1'b1;
  assign pslverr = s_r.slverr & psel & penable;
  assign prdata = s_r.rdata;
  assign nmi_trap = s_r.trap;
  assign irq_out = s_r.irq;
  assign irq_vector = s_r.vec;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  pend_read_clear_a: assert property ( // RULE_01
    (rd && paddr == `ICU_OFF_NMI_STAT && !(fall && trap_ok)) |=> !s_r.pend)
    else $error("pending flag not cleared by read");

  pend_set_a: assert property ( // RULE_02
    (fall && trap_ok) |=> (s_r.pend && nmi_trap))
    else $error("enabled edge did not set pending and trap");

  oneshot_clear_a: assert property ( // RULE_03
    (fall && s_r.en && !wr) |=> (nmi_trap && !s_r.en))
    else $error("one-shot enable not cleared by trap");

  lock_trap_a: assert property ( // RULE_04
    (s_r.lock && fall) |=> nmi_trap)
    else $error("locked trap missed an edge");

  no_trap_off_a: assert property ( // RULE_05
    (!s_r.lock && !s_r.en) |=> !nmi_trap)
    else $error("trap raised while disabled");

  pin_read_a: assert property ( // RULE_07
    (setup && paddr == `ICU_OFF_NMI_CTRL) |=> prdata[`ICU_BIT_PIN] == $past(nmi_s))
    else $error("pin bit does not follow pin");

  lock_hold_a: assert property ( // RULE_19
    s_r.lock |=> s_r.lock)
    else $error("lock enable was cleared");

  vec_track_a: assert property ( // RULE_23
    (found && $stable(win)) [*2] |-> irq_vector == 6'(win) + `ICU_VEC_BASE)
    else $error("vector not winner plus sixteen");

  irq_req_a: assert property ( // RULE_24
    (|req_eff) |=> (irq_out && irq_vector[5:4] != 2'h0))
    else $error("enabled request not sent to core");

  vec_read_a: assert property ( // RULE_09
    (setup && paddr == `ICU_OFF_VECTOR) |=> prdata == {26'h0, $past(irq_vector)})
    else $error("vector upper bits not zero");

  dbg_req_a: assert property ( // RULE_16
    $rose(irq_out) |=> s_r.dbg_req == $past(irq_vector))
    else $error("debug did not capture sent vector");

  // ----------------------------------------
  // NMI trap assertions
  // ----------------------------------------
  trap_pulse_a: assert property ( // RULE_25
    nmi_trap |=> !nmi_trap)
    else $error("trap wider than one cycle");

  trap_edge_a: assert property ( // RULE_22
    nmi_trap |-> ($past(nmi_s, 2) && !$past(nmi_s)))
    else $error("trap without a synchronised falling edge");

  oneshot_trap_a: assert property ( // RULE_03
    (s_r.en && fall) |=> nmi_trap)
    else $error("one-shot enable missed an edge");

  lock_over_en_a: assert property ( // RULE_05
    (s_r.lock && !s_r.en && fall) |=> nmi_trap)
    else $error("lock did not override cleared one-shot enable");

  off_no_flag_a: assert property ( // RULE_05
    (fall && !s_r.lock && !s_r.en && !rd) |=> s_r.pend == $past(s_r.pend))
    else $error("disabled edge changed pending flag");

  pend_hold_a: assert property ( // RULE_01
    (s_r.pend && !(rd && paddr == `ICU_OFF_NMI_STAT)) |=> s_r.pend)
    else $error("pending flag lost without a status read");

  stat_read_a: assert property ( // RULE_02
    (setup && paddr == `ICU_OFF_NMI_STAT) |=> prdata == {31'h0, $past(s_r.pend)})
    else $error("status read does not show pending flag");

  en_write_a: assert property ( // RULE_03
    (wr && paddr == `ICU_OFF_NMI_CTRL) |=> s_r.en == $past(pwdata[`ICU_BIT_EN]))
    else $error("one-shot enable write lost");

  lock_set_a: assert property ( // RULE_19
    (wr && paddr == `ICU_OFF_NMI_CTRL && pwdata[`ICU_BIT_LOCK]) |=> s_r.lock)
    else $error("lock enable write lost");

  // ----------------------------------------
  // Maskable request assertions
  // ----------------------------------------
  req_zero_a: assert property ( // RULE_21
    (irq_req[31:1] == 31'h0) |=> !irq_out)
    else $error("reserved request zero reached the core");

  top_prio_a: assert property ( // RULE_12
    (irq_req[31] && s_r.mask[31]) |=> irq_vector == 6'h2f)
    else $error("top request did not win");

  vec_none_a: assert property ( // RULE_10
    (req_eff == 32'h0) |=> (!irq_out && irq_vector == `ICU_VEC_NONE))
    else $error("vector or request left without a source");

  irq_level_a: assert property ( // RULE_20
    (irq_out && $stable(irq_req) && $stable(s_r.mask)) |=> irq_out)
    else $error("held request dropped");

  mask_lo_a: assert property ( // RULE_13
    (wr && paddr == `ICU_OFF_MASK_LO) |=> s_r.mask[15:0] == $past(pwdata[15:0]))
    else $error("low mask write lost");

  mask_hi_a: assert property ( // RULE_14
    (wr && paddr == `ICU_OFF_MASK_HI) |=> s_r.mask[31:16] == $past(pwdata[15:0]))
    else $error("high mask write lost");

  level_lo_a: assert property ( // RULE_15
    (setup && paddr == `ICU_OFF_LEVEL_LO) |=> prdata == {16'h0, $past(irq_req[15:1]), 1'b0})
    else $error("low level read does not show inputs");

  level_hi_a: assert property ( // RULE_15
    (setup && paddr == `ICU_OFF_LEVEL_HI) |=> prdata == {16'h0, $past(irq_req[31:16])})
    else $error("high level read does not show inputs");

  dbg_ack_a: assert property ( // RULE_11
    ack_read |=> s_r.dbg_rd == $past(irq_vector))
    else $error("acknowledge read not captured");

endmodule // icu_top
`default_nettype wire

// file: tb/icu_core_model.sv
// Behavioural core and NMI source facing the interrupt control unit
`timescale 1ns/1ns
`default_nettype none
module icu_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic nmi_fall,
  input wire logic ack_go,
  input wire logic nmi_trap,
  output logic nmi_pin_n,
  output logic ack_read,
  output int trap_cnt
);
  int low_cnt;
  // ----------------------------------------
  // Pin source and acknowledge strobe
  // ----------------------------------------
  // Pin is held low for 8 cycles so that the two-flop sync always sees it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_pin_n <= 1'b1;
      low_cnt <= 0;
      trap_cnt <= 0;
      ack_read <= 1'b0;
    end else begin
      ack_read <= ack_go;
      if (nmi_trap) begin
        trap_cnt <= trap_cnt + 1;
      end
      if (nmi_fall) begin
        nmi_pin_n <= 1'b0;
        low_cnt <= 8;
      end else if (low_cnt > 1) begin
        low_cnt <= low_cnt - 1;
      end else begin
        nmi_pin_n <= 1'b1;
      end
    end
  end
endmodule // icu_core_model
`default_nettype wire

// file: tb/icu_top_tb_top.sv
// Self-checking bench for the interrupt control unit
`timescale 1ns/1ns
`default_nettype none
`include "icu_consts.svh"
module icu_top_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, nmi_fall = 0, ack_go = 0, e;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, irq_req = 0, q, m, r;
  wire [31:0] prdata;
  wire pready, pslverr, nmi_pin_n, ack_read, nmi_trap, irq_out;
  wire [5:0] irq_vector;
  int trap_cnt, err_total = 0, cmp_count = 0, seed = 49;
  // Model of masks, requests and the vector captured at each request rise
  logic [31:0] km = 32'hffff_ffff, kr = 0;
  logic [5:0] dq = 0;
  logic iq = 0;
  icu_top icu_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nmi_pin_n(nmi_pin_n), .irq_req(irq_req), .ack_read(ack_read), .nmi_trap(nmi_trap),
    .irq_out(irq_out), .irq_vector(irq_vector));
  icu_core_model icu_core_model_inst (.pclk(pclk), .presetn(presetn), .nmi_fall(nmi_fall), .ack_go(ack_go),
    .nmi_trap(nmi_trap), .nmi_pin_n(nmi_pin_n), .ack_read(ack_read), .trap_cnt(trap_cnt));
  // ----------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------
  always #25 pclk = ~pclk;
  // Whole run needs about 710 cycles, so 4000 is generous
  initial begin
    #200000;
    err_total++;
    finish_test();
  end
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Setup cycle, then access held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic fall_nmi(input int gap);
    @(posedge pclk);
    nmi_fall <= 1'b1;
    @(posedge pclk);
    nmi_fall <= 1'b0;
    repeat (gap) @(posedge pclk);
  endtask
  // Reference encoder: scan upward so the highest number wins
  function automatic logic [5:0] exp_vec(input logic [31:0] rq, input logic [31:0] k);
    logic [5:0] v;
    v = 6'h00;
    for (int i = 1; i < 32; i++) begin
      if (rq[i] && k[i]) v = 6'(i + 16);
    end
    return v;
  endfunction
  // Request to the core rises: the debug field keeps the vector of that moment
  task automatic upd;
    if ((|(kr & km & 32'hfffffffe)) && !iq) dq = exp_vec(kr, km);
    iq = |(kr & km & 32'hfffffffe);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ICU_OFF_MASK_LO, 32'hffff);
    rd(`ICU_OFF_MASK_HI, 32'hffff);
    rd(`ICU_OFF_DEBUG, 32'h0);
    rd(`ICU_OFF_NMI_CTRL, 32'h2);
    rd(`ICU_OFF_NMI_STAT, 32'h0);
    rd(8'h20, 32'h0);
    chk(e, 1'b1);
    $display("reset and map test done");
    // Random masks and sparse requests against the reference encoder
    for (int t = 0; t < 20; t++) begin
      m = $random(seed);
      r = $random(seed) & $random(seed) & $random(seed);
      apb(1'b1, `ICU_OFF_MASK_LO, {16'h0, m[15:0]});
      km[15:0] = m[15:0];
      upd();
      apb(1'b1, `ICU_OFF_MASK_HI, {16'h0, m[31:16]});
      irq_req <= r;
      km[31:16] = m[31:16];
      kr = r;
      upd();
      repeat (3) @(posedge pclk);
      chk(irq_vector, exp_vec(r, m));
      chk(irq_out, |(r & m & 32'hfffffffe));
      rd(`ICU_OFF_MASK_LO, {16'h0, m[15:0]});
      rd(`ICU_OFF_LEVEL_LO, {16'h0, r[15:1], 1'b0});
      rd(`ICU_OFF_LEVEL_HI, {16'h0, r[31:16]});
      rd(`ICU_OFF_VECTOR, {26'h0, exp_vec(r, m)});
      // Odd rounds drop the requests so the acknowledge capture differs from the read
      if (t[0]) begin
        irq_req <= 32'h0;
        kr = 0;
        upd();
      end
      @(posedge pclk);
      ack_go <= 1'b1;
      @(posedge pclk);
      ack_go <= 1'b0;
      repeat (2) @(posedge pclk);
      apb(1'b0, `ICU_OFF_DEBUG, 32'h0);
      chk(q & 32'hfff, {20'h0, dq, (t[0] ? 6'h00 : exp_vec(r, m))});
    end
    $display("maskable test done");
    // Disabled trap, pin level seen while low
    fall_nmi(4);
    rd(`ICU_OFF_NMI_CTRL, 32'h0);
    repeat (14) @(posedge pclk);
    chk(trap_cnt, 0);
    rd(`ICU_OFF_NMI_STAT, 32'h0);
    // One-shot enable: one trap, then disabled
    apb(1'b1, `ICU_OFF_NMI_CTRL, 32'h1);
    fall_nmi(14);
    chk(trap_cnt, 1);
    rd(`ICU_OFF_NMI_STAT, 32'h1);
    rd(`ICU_OFF_NMI_STAT, 32'h0);
    rd(`ICU_OFF_NMI_CTRL, 32'h2);
    fall_nmi(14);
    chk(trap_cnt, 1);
    // Lock enable: every edge traps and a zero write cannot clear it
    apb(1'b1, `ICU_OFF_NMI_CTRL, 32'h4);
    fall_nmi(14);
    fall_nmi(14);
    chk(trap_cnt, 3);
    apb(1'b1, `ICU_OFF_NMI_CTRL, 32'h8);
    rd(`ICU_OFF_NMI_CTRL, 32'he);
    fall_nmi(14);
    chk(trap_cnt, 4);
    $display("nmi test done");
    finish_test();
  end
endmodule // icu_top_tb_top
`default_nettype wire
